// ==== core/wdt_pkg.sv ====
// constants, types and bus carrier for the watchdog, supply monitor and reset flags
// Behaviour
// - timeout in interrupt mode sets interrupt flag
// - vector execution clears interrupt flag
// - writing one clears interrupt flag
// - flag and enable request watchdog interrupt
// - interrupt mode gives interrupt, no reset
// - combined mode first timeout only sets flag
// - combined vector clears enable and flag
// - combined timeout with pending flag resets
// - programmed fuse forces reset on timeout
// - reset flag forces reset enable on
// - timeout is base cycles shifted by select
// - control bit four reads zero
// - supply below flag level sets flag
// - flag clears when disabled or recovered
// - enabled supply interrupt on flag rising
// - reset codes give power-on reset, no flag
// - flag codes set flag and interrupt
// - watchdog reset sets flag, power-on clears
// - external reset sets flag, power-on clears
// - power-on flag cleared only by software
// - counter runs on slow tick, clears often
// - disable or fused change needs unlock window
// - watchdog reset is one-cycle pulse
// - supply reset held while supply low
package wdt_pkg;
  // =====================================================================
  // register map: printed offsets are indices, byte address is four times
  localparam int unsigned IDX_WDT = 'h31;
  localparam int unsigned IDX_SUP = 'h34;
  localparam int unsigned IDX_RST = 'h3b;
  localparam logic [7:0] ADDR_WDT = 8'(IDX_WDT * 4);
  localparam logic [7:0] ADDR_SUP = 8'(IDX_SUP * 4);
  localparam logic [7:0] ADDR_RST = 8'(IDX_RST * 4);
  // =====================================================================
  // field positions
  localparam int unsigned WD_IF_BIT = 7;
  localparam int unsigned WD_IE_BIT = 6;
  localparam int unsigned WD_SEL3_BIT = 5;
  localparam int unsigned WD_RE_BIT = 3;
  localparam int unsigned SUP_F_BIT = 7;
  localparam int unsigned SUP_IE_BIT = 6;
  localparam int unsigned RF_WD_BIT = 3;
  localparam int unsigned RF_EXT_BIT = 1;
  localparam int unsigned RF_POR_BIT = 0;
  // =====================================================================
  // codes and timing
  localparam logic [3:0] WD_SEL_MAX = 4'h9;
  localparam logic [2:0] SUP_OFF = 3'h0;
  localparam logic [2:0] SUP_RST_LO = 3'h1;
  localparam logic [2:0] SUP_RST_HI = 3'h2;
  localparam logic [2:0] SUP_FLAG_LO = 3'h3;
  localparam logic [2:0] SUP_FLAG_HI = 3'h4;
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
  localparam int unsigned WD_BASE_CYCLES = 2048;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned SYS_CLK_KHZ = 50000;
  localparam int unsigned WD_OSC_KHZ = 128;
  localparam int unsigned OSC_DIV_DEFAULT = SYS_CLK_KHZ / WD_OSC_KHZ;
  localparam int unsigned DIV_W = 16;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // =====================================================================
  // types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
  typedef enum logic [1:0] {WD_STOPPED, WD_IRQ, WD_RESET, WD_IRQ_RESET} wd_mode_t;
endpackage

// ==== core/watchdog_supply_monitor_reset_flags.sv ====
// watchdog timer, supply level monitor and reset-cause flag registers
`timescale 1ns/1ps
`default_nettype none
module watchdog_supply_monitor_reset_flags #(
  parameter int unsigned TIMEOUT_BASE = wdt_pkg::WD_BASE_CYCLES,
  parameter int unsigned OSC_DIV = wdt_pkg::OSC_DIV_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire wdt_pkg::bus_req_t req,
  output logic [7:0] rdata,
  // core events
  input wire logic watchdog_restart,
  input wire logic wdt_vector_taken,
  input wire logic change_protection_unlock,
  input wire logic external_reset_pulse,
  // fuse and analog comparator
  input wire logic watchdog_always_on_fuse,
  input wire logic supply_below_level,
  // requests
  output logic wdt_irq,
  output logic supply_irq,
  output logic wdt_reset_pulse,
  output logic supply_reset_hold
);

  // =====================================================================
  // elaboration checks
  if (TIMEOUT_BASE < 1 || TIMEOUT_BASE > wdt_pkg::WD_BASE_CYCLES) begin : g_chk_base
    $error("TIMEOUT_BASE out of range");
  end
  if (OSC_DIV < 1 || OSC_DIV >= (1 << wdt_pkg::DIV_W)) begin : g_chk_div
    $error("OSC_DIV out of range");
  end

  // =====================================================================
  // state
  logic fuse_on;
  logic [2:0] unlock_cnt;
  logic [wdt_pkg::DIV_W-1:0] osc_cnt;
  logic [wdt_pkg::CNT_W:0] wd_cnt;
  logic watchdog_interrupt_flag, watchdog_interrupt_enable, watchdog_reset_enable;
  logic [3:0] wdp;
  logic sup_flag, sup_ie;
  logic [2:0] sup_sel;
  logic watchdog_reset_flag, external_reset_flag, power_on_reset_flag;
  logic next_watchdog_interrupt_flag, next_watchdog_interrupt_enable, next_wde;
  logic [3:0] next_wdp;
  logic next_watchdog_reset_flag, next_external_reset_flag, next_power_on_reset_flag;

  // =====================================================================
  // bus decode
  wire wr_wdt = req.wr && req.addr == wdt_pkg::ADDR_WDT;
  wire wr_sup = req.wr && req.addr == wdt_pkg::ADDR_SUP;
  wire wr_rst = req.wr && req.addr == wdt_pkg::ADDR_RST;
  wire [7:0] d = req.wdata;
  wire [3:0] d_wdp_raw = {d[wdt_pkg::WD_SEL3_BIT], d[2:0]};
  // reserved selects clamp to the longest legal period
  wire [3:0] d_wdp = (d_wdp_raw > wdt_pkg::WD_SEL_MAX) ? wdt_pkg::WD_SEL_MAX : d_wdp_raw;
  wire [2:0] d_sel = (d[2:0] > wdt_pkg::SUP_FLAG_HI) ? wdt_pkg::SUP_FLAG_HI : d[2:0];

  // =====================================================================
  // watchdog mode
  wire unlocked = unlock_cnt != 3'h0;
  wire wde_eff = watchdog_reset_enable | watchdog_reset_flag | fuse_on;
  wire wd_running = wde_eff | watchdog_interrupt_enable;
  wdt_pkg::wd_mode_t mode;
  // fuse overrides both enable bits
  assign mode = (fuse_on || (wde_eff && !watchdog_interrupt_enable)) ? wdt_pkg::WD_RESET :
                (wde_eff && watchdog_interrupt_enable) ? wdt_pkg::WD_IRQ_RESET :
                watchdog_interrupt_enable ? wdt_pkg::WD_IRQ : wdt_pkg::WD_STOPPED;

  // =====================================================================
  // slow tick and timeout
  wire osc_tick = osc_cnt == wdt_pkg::DIV_W'(OSC_DIV - 1);
  wire [wdt_pkg::CNT_W:0] wd_period = (wdt_pkg::CNT_W + 1)'(TIMEOUT_BASE) << wdp;
  wire [wdt_pkg::CNT_W:0] wd_last = wd_period - (wdt_pkg::CNT_W + 1)'(1);
  wire timeout = osc_tick && wd_running && wd_cnt == wd_last;
  // a pending flag at the second timeout means the handler never ran
  wire fire_reset = timeout && (mode == wdt_pkg::WD_RESET ||
                    (mode == wdt_pkg::WD_IRQ_RESET && watchdog_interrupt_flag));
  wire set_watchdog_interrupt_flag = timeout && (mode == wdt_pkg::WD_IRQ ||
                  (mode == wdt_pkg::WD_IRQ_RESET && !watchdog_interrupt_flag));
  wire sup_is_rst = sup_sel == wdt_pkg::SUP_RST_LO || sup_sel == wdt_pkg::SUP_RST_HI;
  wire sup_is_flag = sup_sel == wdt_pkg::SUP_FLAG_LO || sup_sel == wdt_pkg::SUP_FLAG_HI;
  // a supply-monitor reset acts like a power-on reset on the flags
  wire por_event = supply_reset_hold;
  wire dev_reset = fire_reset || external_reset_pulse || por_event;
  wire next_sup_flag = sup_is_flag && supply_below_level;
  wire next_sup_hold = sup_is_rst && supply_below_level;

  // =====================================================================
  // watchdog control next values
  always_comb begin
    next_watchdog_interrupt_flag = watchdog_interrupt_flag;
    next_watchdog_interrupt_enable = watchdog_interrupt_enable;
    next_wde = watchdog_reset_enable;
    next_wdp = wdp;
    if (wr_wdt) begin
      next_watchdog_interrupt_enable = d[wdt_pkg::WD_IE_BIT];
      // enabling is free, disabling needs the window and a clear reset flag
      next_wde = d[wdt_pkg::WD_RE_BIT] | (watchdog_reset_enable & !(unlocked && !watchdog_reset_flag));
      if (!fuse_on || unlocked) begin
        next_wdp = d_wdp;
      end
    end
    if (wdt_vector_taken && mode == wdt_pkg::WD_IRQ_RESET) begin
      next_watchdog_interrupt_enable = 1'b0;
    end
    // clear by vector or by writing one; a new timeout wins over both
    if ((wr_wdt && d[wdt_pkg::WD_IF_BIT]) || wdt_vector_taken) begin
      next_watchdog_interrupt_flag = 1'b0;
    end
    if (set_watchdog_interrupt_flag) begin
      next_watchdog_interrupt_flag = 1'b1;
    end
    if (dev_reset) begin
      next_watchdog_interrupt_flag = 1'b0;
      next_watchdog_interrupt_enable = 1'b0;
      next_wdp = 4'h0;
    end
  end

  // =====================================================================
  // reset flag next values; a set in the clearing cycle wins
  always_comb begin
    next_watchdog_reset_flag = watchdog_reset_flag;
    next_external_reset_flag = external_reset_flag;
    next_power_on_reset_flag = power_on_reset_flag;
    if (wr_rst) begin
      next_watchdog_reset_flag = watchdog_reset_flag & d[wdt_pkg::RF_WD_BIT];
      next_external_reset_flag = external_reset_flag & d[wdt_pkg::RF_EXT_BIT];
      next_power_on_reset_flag = power_on_reset_flag & d[wdt_pkg::RF_POR_BIT];
    end
    if (fire_reset) begin
      next_watchdog_reset_flag = 1'b1;
    end
    if (external_reset_pulse) begin
      next_external_reset_flag = 1'b1;
    end
    if (por_event) begin
      next_watchdog_reset_flag = 1'b0;
      next_external_reset_flag = 1'b0;
      next_power_on_reset_flag = 1'b1;
    end
  end

  // =====================================================================
  // read mux; unused bits read zero
  wire [7:0] rd_wdt = {watchdog_interrupt_flag, watchdog_interrupt_enable, wdp[3], 1'b0, wde_eff, wdp[2:0]};
  wire [7:0] rd_sup = {sup_flag, sup_ie, 3'b000, sup_sel};
  wire [7:0] rd_rst = {4'h0, watchdog_reset_flag, 1'b0, external_reset_flag, power_on_reset_flag};
  wire [7:0] rd_mux = (req.addr == wdt_pkg::ADDR_WDT) ? rd_wdt :
                      (req.addr == wdt_pkg::ADDR_SUP) ? rd_sup :
                      (req.addr == wdt_pkg::ADDR_RST) ? rd_rst : wdt_pkg::RDATA_IDLE;

  // =====================================================================
  // fuse sampled at reset; the strap is static in normal use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fuse_on <= !watchdog_always_on_fuse;
    end
  end

  // unlock window of a few cycles after the signature
  always_ff @(posedge ref_clk) begin
    if (rst || change_protection_unlock) begin
      unlock_cnt <= rst ? 3'h0 : wdt_pkg::UNLOCK_WINDOW;
    end else if (unlocked) begin
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  // slow oscillator stand-in, free running
  always_ff @(posedge ref_clk) begin
    if (rst || osc_tick) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + wdt_pkg::DIV_W'(1);
    end
  end

  // watchdog counter: restart, disable, reset and timeout all clear it
  always_ff @(posedge ref_clk) begin
    if (rst || dev_reset || watchdog_restart || !wd_running || timeout) begin
      wd_cnt <= '0;
    end else if (osc_tick) begin
      wd_cnt <= wd_cnt + (wdt_pkg::CNT_W + 1)'(1);
    end
  end

  // watchdog control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_interrupt_flag <= 1'b0;
      watchdog_interrupt_enable <= 1'b0;
      watchdog_reset_enable <= 1'b0;
      wdp <= 4'h0;
    end else begin
      watchdog_interrupt_flag <= next_watchdog_interrupt_flag;
      watchdog_interrupt_enable <= next_watchdog_interrupt_enable;
      watchdog_reset_enable <= next_wde;
      wdp <= next_wdp;
    end
  end

  // supply monitor register and flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sup_ie <= 1'b0;
      sup_sel <= wdt_pkg::SUP_OFF;
      sup_flag <= 1'b0;
    end else begin
      if (wr_sup) begin
        sup_ie <= d[wdt_pkg::SUP_IE_BIT];
        sup_sel <= d_sel;
      end
      sup_flag <= next_sup_flag;
    end
  end

  // reset cause flags; rst itself is the power-on reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_reset_flag <= 1'b0;
      external_reset_flag <= 1'b0;
      power_on_reset_flag <= 1'b1;
    end else begin
      watchdog_reset_flag <= next_watchdog_reset_flag;
      external_reset_flag <= next_external_reset_flag;
      power_on_reset_flag <= next_power_on_reset_flag;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= wdt_pkg::RDATA_IDLE;
      wdt_irq <= 1'b0;
      supply_irq <= 1'b0;
      wdt_reset_pulse <= 1'b0;
      supply_reset_hold <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_mux : wdt_pkg::RDATA_IDLE;
      wdt_irq <= next_watchdog_interrupt_flag && next_watchdog_interrupt_enable;
      supply_irq <= next_sup_flag && !sup_flag && sup_ie;
      wdt_reset_pulse <= fire_reset;
      supply_reset_hold <= next_sup_hold;
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_watchdog_interrupt_flag_on_timeout: assert property (set_watchdog_interrupt_flag |=> watchdog_interrupt_flag)
    else $error("timeout did not set watchdog flag");
  a_vector_clears: assert property (wdt_vector_taken && !set_watchdog_interrupt_flag |=> !watchdog_interrupt_flag)
    else $error("vector did not clear watchdog flag");
  a_write_one_clears: assert property (wr_wdt && d[7] && !set_watchdog_interrupt_flag |=> !watchdog_interrupt_flag)
    else $error("writing one did not clear flag");
  a_irq_tracks_flag: assert property (wdt_irq == (watchdog_interrupt_flag && watchdog_interrupt_enable))
    else $error("watchdog irq not flag and enable");
  a_irq_mode_quiet: assert property (timeout && mode == wdt_pkg::WD_IRQ
    |=> !wdt_reset_pulse && watchdog_interrupt_flag)
    else $error("interrupt mode caused a reset");
  a_first_timeout: assert property (timeout && mode == wdt_pkg::WD_IRQ_RESET && !watchdog_interrupt_flag
    |=> watchdog_interrupt_flag && !wdt_reset_pulse)
    else $error("combined first timeout wrong");
  a_combined_vector: assert property (wdt_vector_taken && mode == wdt_pkg::WD_IRQ_RESET
    && !set_watchdog_interrupt_flag |=> !watchdog_interrupt_enable && !watchdog_interrupt_flag)
    else $error("combined vector did not drop enable");
  a_second_timeout: assert property (timeout && mode == wdt_pkg::WD_IRQ_RESET && watchdog_interrupt_flag
    |=> wdt_reset_pulse ##1 !wdt_reset_pulse)
    else $error("pending flag timeout did not reset");
  a_fuse_reset: assert property (timeout && fuse_on |=> wdt_reset_pulse && watchdog_reset_flag)
    else $error("fused timeout did not reset");
  a_wde_forced: assert property (req.rd && req.addr == wdt_pkg::ADDR_WDT && watchdog_reset_flag
    |=> rdata[3] && !rdata[4])
    else $error("reset enable not forced or bit four set");
  a_sup_flag: assert property (sup_is_flag && supply_below_level |=> sup_flag)
    else $error("supply flag not set");
  a_sup_clear: assert property (sup_sel == wdt_pkg::SUP_OFF |=> !sup_flag)
    else $error("supply flag not cleared when off");
  a_sup_irq: assert property (supply_irq |-> sup_flag && !$past(sup_flag))
    else $error("supply irq without new flag");
  a_sup_reset: assert property (sup_is_rst && supply_below_level
    |=> supply_reset_hold && !sup_flag ##1 power_on_reset_flag)
    else $error("supply reset code misbehaved");
  a_ext_flag: assert property (external_reset_pulse && !por_event |=> external_reset_flag)
    else $error("external reset flag not set");

  c_combined: cover property (set_watchdog_interrupt_flag && mode == wdt_pkg::WD_IRQ_RESET
    ##[1:1000] wdt_reset_pulse);
  c_fuse_reset: cover property (fuse_on && wdt_reset_pulse);
  c_sup_irq: cover property (supply_irq);
  c_sup_hold: cover property (supply_reset_hold);

endmodule
`default_nettype wire

// ==== dv/watchdog_supply_monitor_reset_flags_tb.sv ====
// self-checking bench for the watchdog, supply monitor and reset flags
`timescale 1ns/1ps
`default_nettype none
module watchdog_supply_monitor_reset_flags_tb;
  // ==================================================================
  // stimulus, observed outputs and bookkeeping
  localparam logic [7:0] CT = wdt_pkg::ADDR_WDT;
  localparam logic [7:0] SU = wdt_pkg::ADDR_SUP;
  localparam logic [7:0] RF = wdt_pkg::ADDR_RST;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wdt_pkg::bus_req_t req = '0;
  logic watchdog_restart = 1'b0;
  logic wdt_vector_taken = 1'b0;
  logic change_protection_unlock = 1'b0;
  logic external_reset_pulse = 1'b0;
  logic watchdog_always_on_fuse = 1'b1;
  logic supply_below_level = 1'b0;
  logic [7:0] rdata;
  logic wdt_irq, supply_irq, wdt_reset_pulse, supply_reset_hold;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] val;
  int bad_count = 0;
  int cmp_count = 0;
  int pulses = 0;
  int sirqs = 0;
  int cycles = 0;
  int seed = 25999;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // short base and divider keep every awaited time-out within 64 cycles
  watchdog_supply_monitor_reset_flags #(.TIMEOUT_BASE(4), .OSC_DIV(2))
      watchdog_supply_monitor_reset_flags_i (
    .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
    .watchdog_restart(watchdog_restart), .wdt_vector_taken(wdt_vector_taken),
    .change_protection_unlock(change_protection_unlock),
    .external_reset_pulse(external_reset_pulse),
    .watchdog_always_on_fuse(watchdog_always_on_fuse),
    .supply_below_level(supply_below_level), .wdt_irq(wdt_irq), .supply_irq(supply_irq),
    .wdt_reset_pulse(wdt_reset_pulse), .supply_reset_hold(supply_reset_hold));

  // ==================================================================
  // shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one strobe cycle; a read leaves its expectation for the watcher
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    @(posedge ref_clk);
    change_protection_unlock <= 1'b0;
    req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    if (!w) exp_q.push_back(e);
    @(posedge ref_clk);
    req <= '0;
  endtask

  // 0 vector taken, otherwise external reset
  task automatic pulse(input int k);
    @(posedge ref_clk);
    if (k == 0) wdt_vector_taken <= 1'b1;
    else external_reset_pulse <= 1'b1;
    @(posedge ref_clk);
    wdt_vector_taken <= 1'b0;
    external_reset_pulse <= 1'b0;
  endtask

  // sampled mid-cycle so a one-cycle pulse is never missed nor raced
  task automatic wait_ev(input int k, input string what);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (n < 3000 && (k == 0 ? wdt_irq : wdt_reset_pulse) !== 1'b1);
    check({7'h00, n < 3000}, 8'h01, what);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  // ==================================================================
  // watcher: read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    cycles++;
    if (wdt_reset_pulse === 1'b1) pulses++;
    if (supply_irq === 1'b1) sirqs++;
    if (rd_seen && exp_q.size() > 0) check(rdata, exp_q.pop_front(), "read data");
    rd_seen <= req.rd;
    if (cycles == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ==================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    bus(0, CT, 0, 8'h00);
    bus(0, SU, 0, 8'h00);
    bus(0, RF, 0, 8'h01);
    bus(0, 8'h10, 0, 8'h00);
    // random selects with the spare bit random; codes above nine fold to nine
    repeat (6) begin
      val = 8'($random(seed)) & 8'h37;
      bus(1, CT, val, 0);
      if ({val[5], val[2:0]} > 4'h9) val = 8'h21;
      bus(0, CT, 0, val & 8'h27);
    end
    // interrupt mode
    bus(1, CT, 8'h43, 0);
    wait_ev(0, "irq mode timeout");
    bus(0, CT, 0, 8'hc3);
    pulse(0);
    bus(0, CT, 0, 8'h43);
    wait_ev(0, "irq mode second timeout");
    bus(1, CT, 8'h43, 0);
    bus(0, CT, 0, 8'hc3);
    bus(1, CT, 8'h80, 0);
    bus(0, CT, 0, 8'h00);
    @(negedge ref_clk);
    check(8'(pulses), 8'h00, "reset in irq mode");
    // combined mode, vector taken, then plain reset mode
    bus(1, CT, 8'h4b, 0);
    wait_ev(0, "combined first timeout");
    @(negedge ref_clk);
    check(8'(pulses), 8'h00, "reset on first combined timeout");
    pulse(0);
    bus(0, CT, 0, 8'h0b);
    wait_ev(1, "reset after vector");
    bus(0, RF, 0, 8'h09);
    bus(1, CT, 8'h00, 0);
    bus(0, CT, 0, 8'h08);
    do_reset();
    bus(0, RF, 0, 8'h01);
    // combined mode with the interrupt left pending
    bus(1, CT, 8'h4b, 0);
    wait_ev(0, "combined pending");
    wait_ev(1, "pending second timeout");
    bus(0, CT, 0, 8'h08);
    do_reset();
    // disabling needs the unlock window
    // keep the long period so no timeout sets the reset flag mid-scenario
    bus(1, CT, 8'h0f, 0);
    bus(1, CT, 8'h07, 0);
    bus(0, CT, 0, 8'h0f);
    @(posedge ref_clk);
    change_protection_unlock <= 1'b1;
    bus(1, CT, 8'h00, 0);
    bus(0, CT, 0, 8'h00);
    // restart held high keeps the counter at zero
    watchdog_restart <= 1'b1;
    pulses = 0;
    bus(1, CT, 8'h08, 0);
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    check(8'(pulses), 8'h00, "timeout under restart");
    watchdog_restart <= 1'b0;
    wait_ev(1, "reset mode timeout");
    bus(0, RF, 0, 8'h09);
    // programmed fuse forces reset mode
    watchdog_always_on_fuse <= 1'b0;
    do_reset();
    bus(0, CT, 0, 8'h08);
    bus(1, CT, 8'h40, 0);
    wait_ev(1, "fused timeout");
    watchdog_always_on_fuse <= 1'b1;
    do_reset();
    // reset cause flags
    pulse(1);
    bus(0, RF, 0, 8'h03);
    bus(1, RF, 8'h00, 0);
    bus(0, RF, 0, 8'h00);
    pulse(1);
    bus(0, RF, 0, 8'h02);
    do_reset();
    bus(0, RF, 0, 8'h01);
    // every trigger code, disallowed ones fold to the highest
    for (int c = 0; c < 8; c++) begin
      val = (c > 4) ? 8'h04 : 8'(c);
      bus(1, SU, 8'h40 | 8'(c), 0);
      @(posedge ref_clk);
      supply_below_level <= 1'b1;
      sirqs = 0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      check({7'h00, supply_reset_hold}, {7'h00, val == 1 || val == 2}, "hold");
      check(8'(sirqs), {7'h00, val >= 3}, "supply irq");
      bus(0, SU, 0, {val >= 3, 1'b1, 3'b000, val[2:0]});
      @(posedge ref_clk);
      supply_below_level <= 1'b0;
      repeat (3) @(posedge ref_clk);
      bus(0, SU, 0, {2'b01, 3'b000, val[2:0]});
    end
    bus(0, RF, 0, 8'h01);
    bus(1, SU, 8'h00, 0);
    repeat (2) @(posedge ref_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
